/* File: rtl/apm_consts.svh */
// Timing constants for the amplifier power and mute sequencer
`ifndef APM_CONSTS_SVH
`define APM_CONSTS_SVH
`define APM_CLK_HZ 10000000
`define APM_INT_MUTE_MS 650
`define APM_PROP_US 200
`define APM_INT_MUTE_CYC ((`APM_CLK_HZ / 1000) * `APM_INT_MUTE_MS)
`define APM_PROP_CYC (((`APM_CLK_HZ / 1000000) * `APM_PROP_US) + 1)
`define APM_RAMP_STEPS 64
`define APM_CNT_W 24
`define APM_RAMP_W 7
`endif

/* File: rtl/apm_pkg.sv */
// Types for the amplifier power and mute sequencer
package apm_pkg;
  typedef enum logic [2:0] {
    APM_OFF = 3'b000,
    APM_INT_MUTE = 3'b001,
    APM_PROP = 3'b011,
    APM_WAIT_UNMUTE = 3'b010,
    APM_RAMP = 3'b110,
    APM_RUN = 3'b111,
    APM_FAULT = 3'b101
  } apm_state_type;

  typedef struct packed {
    logic overcurrent;
    logic overtemp;
    logic power_stage_supply_ok;
    logic logic_supply_ok;
    logic clock_present;
  } apm_sense_type;

  typedef struct packed {
    logic modulator_run;
    logic stage_enable;
    logic stage_hiz;
  } apm_stage_type;
endpackage : apm_pkg

/* File: rtl/apm_sequencer.sv */
// Power-up, mute and fault sequencer for a class-D output stage
`timescale 1ns/1ns
`include "apm_consts.svh"

// Summary of operation
// (R1) Shutdown low: modulator stopped, power stage held high impedance.
// (R2) Shutdown released: modulator runs, stage stays high impedance until unmute.
// (R3) Mute high unmutes with soft ramp; mute low disables the stage.
// (R4) Fixed 650 ms internal mute after shutdown release; no switching.
// (R5) Switching starts only after interval plus 200 us and mute high.
// (R6) Controller holds mute low longer than the internal mute interval.
// (R7) Either supply missing or low inhibits power stage turn-on.
// (R8) Controller lowers mute before lowering shutdown.
// (R9) Any fault shuts the power stage down at once.
// (R10) Overcurrent, overtemp, supply loss or clock loss assert fault flag.
// (R11) Fault flag fed back to mute gives repeated restart under a short; here the flag then holds mute low, so the latch never clears.
// (R12) Fault stays latched until mute goes low then high.
// (R13) Internal mute is a cycle counter restarted by shutdown.
module apm_sequencer #(
  parameter logic [`APM_CNT_W-1:0] INT_MUTE_CYC = `APM_CNT_W'(`APM_INT_MUTE_CYC),
  parameter logic [`APM_CNT_W-1:0] PROP_CYC = `APM_CNT_W'(`APM_PROP_CYC)
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic shutdown_n_input,
  input wire logic mute_n_input,
  input wire apm_pkg::apm_sense_type sense,
  output apm_pkg::apm_stage_type stage,
  output logic [`APM_RAMP_W-1:0] ramp_level,
  output logic fault_flag_n_out,
  output logic fault_flag_n_oe
);
  import apm_pkg::*;

  logic [1:0] shdn_sync_r;
  logic [1:0] mute_sync_r;
  apm_sense_type sense_s1_r;
  apm_sense_type sense_s2_r;
  logic shdn_n;
  logic mute_n;
  logic mute_prev_r;
  logic fault_now;

  // Pins are asynchronous to this clock
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      shdn_sync_r <= 2'b00;
      mute_sync_r <= 2'b00;
      sense_s1_r <= '0;
      sense_s2_r <= '0;
    end else begin
      shdn_sync_r <= {shdn_sync_r[0], shutdown_n_input};
      mute_sync_r <= {mute_sync_r[0], mute_n_input};
      sense_s1_r <= sense;
      sense_s2_r <= sense_s1_r;
    end
  end

  assign shdn_n = shdn_sync_r[1];
  assign mute_n = mute_sync_r[1];
  assign fault_now = sense_s2_r.overcurrent | sense_s2_r.overtemp | ~sense_s2_r.power_stage_supply_ok |
                     ~sense_s2_r.logic_supply_ok | ~sense_s2_r.clock_present; // R10

  apm_state_type state_r, state_nxt;
  logic [`APM_CNT_W-1:0] cnt_r, cnt_nxt;
  logic [`APM_RAMP_W-1:0] ramp_r, ramp_nxt;
  logic fault_r, fault_nxt;
  logic supplies_ok;
  apm_stage_type stage_nxt;
  logic fault_oe_nxt;

  assign supplies_ok = sense_s2_r.power_stage_supply_ok & sense_s2_r.logic_supply_ok;

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    ramp_nxt = ramp_r;
    fault_nxt = fault_r;
    // Latched fault cleared only by a rising mute edge; a new fault wins
    if (fault_r && mute_n && !mute_prev_r) begin
      fault_nxt = 1'b0; // R12
    end
    if (fault_now) begin
      fault_nxt = 1'b1; // R10
    end
    if (!shdn_n) begin
      state_nxt = APM_OFF; // R1
      cnt_nxt = '0; // R13
      ramp_nxt = '0;
    end else begin
      unique case (state_r)
        APM_OFF: begin
          state_nxt = APM_INT_MUTE; // R2
          cnt_nxt = '0;
        end
        APM_INT_MUTE: begin
          // Counts even while mute is high: internal mute overrides it
          if (cnt_r == INT_MUTE_CYC - 1'b1) begin
            state_nxt = APM_PROP; // R4
            cnt_nxt = '0;
          end else begin
            cnt_nxt = cnt_r + 1'b1; // R13
          end
        end
        APM_PROP: begin
          if (cnt_r == PROP_CYC - 1'b1) begin
            state_nxt = APM_WAIT_UNMUTE; // R5
            cnt_nxt = '0;
          end else begin
            cnt_nxt = cnt_r + 1'b1;
          end
        end
        APM_WAIT_UNMUTE: begin
          ramp_nxt = '0;
          if (mute_n && !fault_r && !fault_now && supplies_ok) begin
            state_nxt = APM_RAMP; // R5 R7
          end
        end
        APM_RAMP: begin
          if (fault_now) begin
            state_nxt = APM_FAULT; // R9
            ramp_nxt = '0;
          end else if (!mute_n || !supplies_ok) begin
            state_nxt = APM_WAIT_UNMUTE; // R3 R7
            ramp_nxt = '0;
          end else if (ramp_r == `APM_RAMP_W'(`APM_RAMP_STEPS)) begin
            state_nxt = APM_RUN;
          end else begin
            ramp_nxt = ramp_r + 1'b1; // R3
          end
        end
        APM_RUN: begin
          if (fault_now) begin
            state_nxt = APM_FAULT; // R9
            ramp_nxt = '0;
          end else if (!mute_n || !supplies_ok) begin
            state_nxt = APM_WAIT_UNMUTE; // R3 R7
            ramp_nxt = '0;
          end
        end
        APM_FAULT: begin
          // Feedback of the flag to mute drops mute low and moves to APM_WAIT_UNMUTE; the flag then holds mute low
          ramp_nxt = '0;
          if (!mute_n) begin
            state_nxt = APM_WAIT_UNMUTE; // R11 R12
          end
        end
        default: begin
          // Unused code 100: park safely in the off state
          state_nxt = APM_OFF;
          ramp_nxt = '0;
        end
      endcase
    end
  end

  always_comb begin
    stage_nxt.modulator_run = (state_nxt != APM_OFF); // R1 R2
    stage_nxt.stage_enable = (state_nxt == APM_RAMP) || (state_nxt == APM_RUN); // R3 R5
    stage_nxt.stage_hiz = !stage_nxt.stage_enable; // R1 R9
    fault_oe_nxt = fault_nxt; // R10
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state_r <= APM_OFF;
      cnt_r <= '0;
      ramp_r <= '0;
      fault_r <= 1'b0;
      mute_prev_r <= 1'b0;
      stage <= 3'h1;
      ramp_level <= '0;
      fault_flag_n_out <= 1'b0;
      fault_flag_n_oe <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      ramp_r <= ramp_nxt;
      fault_r <= fault_nxt;
      mute_prev_r <= mute_n;
      stage <= stage_nxt;
      ramp_level <= ramp_nxt;
      fault_flag_n_out <= 1'b0;
      fault_flag_n_oe <= fault_oe_nxt;
    end
  end
endmodule : apm_sequencer

/* File: verif/apm_properties.sv */
// Checker for the power and mute sequencer ports
`timescale 1ns/1ns
module apm_props #(
  parameter logic [23:0] INT_MUTE_CYC = 24'h14,
  parameter logic [23:0] PROP_CYC = 24'h5
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic shutdown_n_input,
  input wire logic mute_n_input,
  input wire apm_pkg::apm_sense_type sense,
  input wire apm_pkg::apm_stage_type stage,
  input wire logic [6:0] ramp_level,
  input wire logic fault_flag_n_out,
  input wire logic fault_flag_n_oe
);
  import apm_pkg::*;
  logic [7:0] up_r;
  logic [7:0] up_nxt;
  logic flt;
  assign flt = sense.overcurrent | sense.overtemp | !sense.power_stage_supply_ok | !sense.logic_supply_ok
    | !sense.clock_present;
  // Saturates so long runs never wrap
  always_comb up_nxt = !shutdown_n_input ? 8'h0 : up_r + 8'(up_r != 8'hff);
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn)
      up_r <= 8'h0;
    else
      up_r <= up_nxt;
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  sequence s_muted; (!mute_n_input)[*4]; endsequence
  sequence s_unmute; $rose(mute_n_input) ##0 (mute_n_input && !flt)[*4]; endsequence
  chk_off_hiz: assert property ((!shutdown_n_input)[*4] |-> stage.stage_hiz && !stage.modulator_run)
    else $error("stage active in shutdown");
  chk_mute_off: assert property (s_muted |-> !stage.stage_enable)
    else $error("stage enabled while muted");
  chk_ramp_soft: assert property ($rose(stage.stage_enable) |-> ramp_level <= 7'h1)
    else $error("turn-on without soft ramp");
  chk_no_early: assert property ($rose(stage.stage_enable) |-> up_r > INT_MUTE_CYC + PROP_CYC)
    else $error("switching inside internal mute");
  chk_supply_gate: assert property ((!(sense.power_stage_supply_ok && sense.logic_supply_ok))[*4]
    |-> !stage.stage_enable)
    else $error("turn-on with a supply missing");
  chk_fault_off: assert property (flt |-> ##3 (fault_flag_n_oe && stage.stage_hiz))
    else $error("fault not flagged or stage not off");
  chk_latch_hold: assert property (s_muted ##0 fault_flag_n_oe |=> fault_flag_n_oe)
    else $error("fault flag lost while muted");
  chk_latch_clear: assert property (s_unmute |-> ##[0:2] !fault_flag_n_oe)
    else $error("fault flag not cleared by mute toggle");
endmodule : apm_props
bind apm_sequencer apm_props #(.INT_MUTE_CYC(INT_MUTE_CYC), .PROP_CYC(PROP_CYC)) u_props (.*);

/* File: verif/apm_host_model.sv */
// Controller model driving the shutdown and mute pins
`timescale 1ns/1ns
module apm_host_model (
  input wire logic clock,
  output logic shutdown_n,
  output logic mute_n
);
  initial shutdown_n = 1'b0;
  initial mute_n = 1'b0;
  task mute(input logic v);
    @(posedge clock);
    #1 mute_n = v;
  endtask : mute
  // Waiting w cycles before unmute lets inputs settle
  task up(input int w);
    @(posedge clock);
    #1 shutdown_n = 1'b1;
    repeat (w) @(posedge clock);
    #1 mute_n = 1'b1;
  endtask : up
  task down();
    mute(1'b0);
    repeat (4) @(posedge clock);
    #1 shutdown_n = 1'b0;
  endtask : down
endmodule : apm_host_model

/* File: verif/apm_sequencer_tb.sv */
// Self-checking bench for the power and mute sequencer
`timescale 1ns/1ns
`define CHK(s, e, g) begin checks++; if ((g) !== (e)) begin fail_count++; \
  $display("mismatch %s exp %0h got %0h", s, e, g); end end
module apm_sequencer_tb;
  import apm_pkg::*;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  apm_sense_type sense = 5'h7;
  apm_stage_type stage;
  logic [6:0] ramp_level;
  logic flag_out;
  logic flag_oe;
  logic sd_n;
  logic mu_n;
  int fail_count = 0;
  int checks = 0;
  int n;
  always #50 clock = ~clock;
  apm_host_model host (.clock(clock), .shutdown_n(sd_n), .mute_n(mu_n));
  apm_sequencer #(.INT_MUTE_CYC(24'h14), .PROP_CYC(24'h5)) dut (.clock(clock), .rstn(rstn),
    .shutdown_n_input(sd_n), .mute_n_input(mu_n), .sense(sense), .stage(stage), .ramp_level(ramp_level),
    .fault_flag_n_out(flag_out), .fault_flag_n_oe(flag_oe));
  task wait_run();
    n = 0;
    // Stage is 110 through the whole ramp, so wait for the top step
    while (ramp_level !== 7'h40 && n < 200) begin
      @(posedge clock);
      n++;
    end
    #1 `CHK("ramp", 7'h40, ramp_level)
    `CHK("running", 3'h6, stage)
  endtask : wait_run
  task t_up_down();
    host.up(40);
    wait_run();
    host.down();
    repeat (4) @(posedge clock);
    #1 `CHK("off", 3'b001, stage)
  endtask : t_up_down
  // Unmute arrives long before the internal mute ends
  task t_early();
    host.up(1);
    repeat (22) @(posedge clock);
    #1 `CHK("early", 1'b0, stage.stage_enable)
    `CHK("awake", 1'b1, stage.modulator_run)
    wait_run();
    `CHK("delay", 1'b1, n >= 67 && n < 200)
  endtask : t_early
  task t_faults();
    for (int i = 0; i < 5; i++) begin
      @(posedge clock);
      #1 sense = 5'h7 ^ (5'h1 << i);
      repeat (4) @(posedge clock);
      #1 `CHK("flag", 1'b1, flag_oe)
      `CHK("flag_out", 1'b0, flag_out)
      `CHK("hiz", 1'b1, stage.stage_hiz)
      sense = 5'h7;
      host.mute(1'b0);
      repeat (5) @(posedge clock);
      #1 `CHK("latched", 1'b1, flag_oe)
      host.mute(1'b1);
      repeat (5) @(posedge clock);
      #1 `CHK("cleared", 1'b0, flag_oe)
      wait_run();
    end
  endtask : t_faults
  task report_and_stop();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : report_and_stop
  initial begin
    repeat (10) @(posedge clock);
    #1 rstn = 1'b1;
    t_up_down();
    t_early();
    t_faults();
    report_and_stop();
  end
  initial begin
    #500000;
    fail_count++;
    report_and_stop();
  end
endmodule : apm_sequencer_tb
